/* File: hdl/fiw_pulse.sv */
`timescale 1ns/1ps

// fixed-width pulse generator, start ignored while busy
module fiw_pulse #(
	parameter int CYCLES = 5120
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      busy
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        busy_d;

	always_comb begin
		cnt_d  = cnt_q;
		busy_d = busy;
		if (busy) begin
			if (cnt_q == 32'(CYCLES - 1)) begin
				busy_d = 1'b0;
				cnt_d  = 32'h0;
			end else begin
				cnt_d = cnt_q + 32'h1;
			end
		end else if (start) begin
			busy_d = 1'b1;
			cnt_d  = 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 32'h0;
			busy  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy  <= busy_d;
		end
	end
endmodule

/* File: hdl/fiw_top.sv */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Operation
// - With the watchdog on, 14 s after adapter connect without bus traffic forces a power cycle.
// - A bus transaction inside the 14 s window cancels the power cycle.
// - The adapter watchdog is off after reset until software sets its enable bit.
// - No interrupt pulse before start-up ends valid, and none at all after a faulty start-up.
// - The interrupt pin is released normally and pulled low for 128 us per interrupt.
// - Each source has a mask bit and a masked source never pulses the pin.
// - Unmasking a still-present condition gives no pulse; only a new rise while unmasked does.
// - Each event sets its flag on the rising edge of its status and sends one 128 us pulse; the code sends one pulse for events rising in one cycle.
// - Termination sets the done flag, resets the safety timer, pauses charging until toggle or recharge.
// - With the option on, reduced-current conditions run the safety timer at half speed.
// - Battery overcurrent sets its flag, stops charging and disconnects the battery.
// - Timer expiry sets its flag, holds charging off until toggle, and restarts only once cleared.
// - Flags hold until read or cleared through the clear register, and a source pulses again only after its flag is cleared.
module fiw_top
	import fiw_pkg::*;
#(
	parameter int WD_LEN    = fiw_pkg::WD_CYCLES,
	parameter int PULSE_LEN = fiw_pkg::INT_PULSE_CYCLES,
	parameter int SAFE_LEN  = fiw_pkg::SAFETY_CYCLES
) (
	// clock and reset
	input  wire logic                        CLK_SYS,
	input  wire logic                        SYS_RST,
	// register port
	input  wire logic [fiw_pkg::ADDR_W-1:0]  REG_ADDR,
	input  wire logic [fiw_pkg::DATA_W-1:0]  REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	output logic      [fiw_pkg::DATA_W-1:0]  REG_RDATA,
	// start-up and supply status
	input  wire logic                        STARTUP_DONE,
	input  wire logic                        STARTUP_FAULT,
	input  wire logic                        ADAPTER_VALID,
	input  wire logic                        CE_ACTIVE,
	input  wire logic                        BUS_XFER,
	// charger status levels
	input  wire logic                        CHG_TERM,
	input  wire logic                        RECHARGE,
	input  wire logic                        IIN_LIMIT,
	input  wire logic                        VIN_REG,
	input  wire logic                        THERM_FOLD,
	input  wire logic                        COOL_REGION,
	input  wire logic                        BAT_OVERCURRENT,
	// interrupt pin and outputs
	output logic                             INT_O,
	output logic                             INT_OE,
	output logic                             IRQ,
	output logic                             CHARGE_ENABLE,
	output logic                             BAT_DISCONNECT,
	output logic                             POWER_CYCLE
);
	import fiw_pkg::*;

	// ----------------------------------------------------------------
	// registers and bus
	// ----------------------------------------------------------------
	logic [NSRC-1:0]   flags_q, flags_d, mask_q, mask_d, lvl_q, lvl;
	logic [NSRC-1:0]   rise, trig, clr;
	logic [1:0]        ctrl_q, ctrl_d;
	logic [DATA_W-1:0] rdata_d;
	logic              irq_d;
	logic              xfer;
	fiw_wd_t           wd_q, wd_d;
	fiw_chg_t          chg_q, chg_d;
	logic              tmr_exp, wd_exp, int_ok_q;

	assign xfer = BUS_XFER | REG_WR | REG_RD;
	assign lvl  = {wd_q == WD_WARN, chg_q == CHG_TFLT, BAT_OVERCURRENT,
		COOL_REGION, THERM_FOLD, VIN_REG, IIN_LIMIT, CHG_TERM};
	assign rise = lvl & ~lvl_q;
	assign trig = rise & ~mask_q & ~flags_q;

	always_comb begin
		clr     = '0;
		mask_d  = mask_q;
		ctrl_d  = ctrl_q;
		rdata_d = '0;
		if (REG_WR) begin
			case (REG_ADDR)
				OFS_CLEAR: clr = REG_WDATA[NSRC-1:0];
				OFS_MASK:  mask_d = REG_WDATA[NSRC-1:0];
				OFS_CTRL:  ctrl_d = REG_WDATA[1:0];
				default:   ;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				OFS_FLAGS: begin
					rdata_d[NSRC-1:0] = flags_q;
					clr = flags_q;
				end
				OFS_MASK:  rdata_d[NSRC-1:0] = mask_q;
				OFS_CTRL:  rdata_d[1:0] = ctrl_q;
				OFS_STATE: rdata_d[5:0] = {int_ok_q, CHARGE_ENABLE,
					chg_q, wd_q};
				default:   rdata_d = '0;
			endcase
		end
		flags_d = (flags_q & ~clr) | rise;
		irq_d   = |(flags_d & ~mask_d);
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			flags_q   <= '0;
			mask_q    <= MASK_RST;
			ctrl_q    <= CTRL_RST;
			lvl_q     <= '0;
			REG_RDATA <= '0;
			IRQ       <= 1'b0;
		end else begin
			flags_q   <= flags_d;
			mask_q    <= mask_d;
			ctrl_q    <= ctrl_d;
			lvl_q     <= lvl;
			REG_RDATA <= rdata_d;
			IRQ       <= irq_d;
		end
	end

	flag_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		rise[BIT_BAT_OC] |=> flags_q[BIT_BAT_OC])
		else $error("overcurrent rise did not set its flag");
	flag_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		flags_q[BIT_CHG_DONE] && !(REG_RD && REG_ADDR == OFS_FLAGS)
		&& !(REG_WR && REG_ADDR == OFS_CLEAR) |=> flags_q[BIT_CHG_DONE])
		else $error("flag dropped without a read");

	// ----------------------------------------------------------------
	// interrupt pulse
	// ----------------------------------------------------------------
	logic int_ok_d, bad_q, bad_d, pend_q, pend_d, start, busy;
	logic [31:0] oe_len_q;

	always_comb begin
		bad_d    = bad_q | (STARTUP_DONE & STARTUP_FAULT & ~int_ok_q);
		int_ok_d = int_ok_q | (STARTUP_DONE & ~STARTUP_FAULT & ~bad_q);
		start    = int_ok_q & ~busy & (pend_q | (|trig));
		pend_d   = int_ok_q & (pend_q | (|trig)) & ~start;
	end

	fiw_pulse #(.CYCLES(PULSE_LEN)) u_pulse (
		.clk   (CLK_SYS),
		.rst   (SYS_RST),
		.start (start),
		.busy  (busy)
	);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			int_ok_q <= 1'b0;
			bad_q    <= 1'b0;
			pend_q   <= 1'b0;
			INT_O    <= 1'b0;
			oe_len_q <= 32'h0;
		end else begin
			int_ok_q <= int_ok_d;
			bad_q    <= bad_d;
			pend_q   <= pend_d;
			INT_O    <= 1'b0;
			oe_len_q <= busy ? oe_len_q + 32'h1 : 32'h0;
		end
	end
	assign INT_OE = busy;

	startup_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!int_ok_q |-> !INT_OE)
		else $error("interrupt pulse before valid start-up");
	pulse_width_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		$fell(INT_OE) |-> $past(oe_len_q) == 32'(PULSE_LEN - 1))
		else $error("interrupt pulse has wrong width");
	masked_quiet_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		mask_q == '1 && !pend_q && !INT_OE |=> !INT_OE)
		else $error("pulse while every source masked");

	// ----------------------------------------------------------------
	// adapter watchdog
	// ----------------------------------------------------------------
	logic [31:0] wd_cnt_q, wd_cnt_d;
	logic        adp_q, pc_d;

	assign wd_exp = wd_cnt_q == 32'(WD_LEN - 1);

	always_comb begin
		wd_d     = wd_q;
		wd_cnt_d = wd_cnt_q;
		pc_d     = 1'b0;
		case (wd_q)
			WD_IDLE: begin
				wd_cnt_d = 32'h0;
				if (ADAPTER_VALID & ~adp_q & ctrl_q[CTRL_WD_EN])
					wd_d = WD_RUN;
			end
			WD_RUN: begin
				wd_cnt_d = wd_cnt_q + 32'h1;
				if (!ctrl_q[CTRL_WD_EN] || !ADAPTER_VALID || xfer) begin
					wd_d     = WD_IDLE;
					wd_cnt_d = 32'h0;
				end else if (ADAPTER_VALID & ~adp_q) begin
					wd_cnt_d = 32'h0;
				end else if (wd_exp) begin
					wd_d     = WD_WARN;
					wd_cnt_d = 32'h0;
				end
			end
			WD_WARN: begin
				wd_cnt_d = wd_cnt_q + 32'h1;
				if (wd_cnt_q == 32'(PULSE_LEN)) begin
					wd_d = WD_CYCLE;
				end
			end
			WD_CYCLE: begin
				pc_d     = 1'b1;
				wd_d     = WD_IDLE;
				wd_cnt_d = 32'h0;
			end
			default: wd_d = WD_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			wd_q        <= WD_IDLE;
			wd_cnt_q    <= 32'h0;
			adp_q       <= 1'b0;
			POWER_CYCLE <= 1'b0;
		end else begin
			wd_q        <= wd_d;
			wd_cnt_q    <= wd_cnt_d;
			adp_q       <= ADAPTER_VALID;
			POWER_CYCLE <= pc_d;
		end
	end

	wd_off_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!ctrl_q[CTRL_WD_EN] && wd_q != WD_WARN && wd_q != WD_CYCLE
		|=> wd_q == WD_IDLE)
		else $error("watchdog ran while disabled");
	wd_stop_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wd_q == WD_RUN && xfer |=> wd_q == WD_IDLE ##1 !POWER_CYCLE)
		else $error("transaction did not stop the watchdog");
	wd_cycle_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		$rose(POWER_CYCLE) |-> $past(wd_q, 2) == WD_WARN
		&& flags_q[BIT_WD_FLT])
		else $error("power cycle without watchdog flag");

	// ----------------------------------------------------------------
	// charger control and safety timer
	// ----------------------------------------------------------------
	logic [31:0] st_cnt_q, st_cnt_d;
	logic        half_q, half_d, slow, tog, tog_q, tog_d, ce_q;
	logic        chg_en_d, disc_d;

	assign tog     = (ADAPTER_VALID ^ adp_q) | (CE_ACTIVE ^ ce_q);
	assign slow    = IIN_LIMIT | VIN_REG | THERM_FOLD | COOL_REGION;
	assign tmr_exp = st_cnt_q == 32'(SAFE_LEN - 1);

	always_comb begin
		chg_d    = chg_q;
		st_cnt_d = st_cnt_q;
		half_d   = half_q;
		tog_d    = tog_q | tog;
		case (chg_q)
			CHG_RUN: begin
				tog_d  = 1'b0;
				half_d = ~half_q;
				if (!(ctrl_q[CTRL_DBL_EN] & slow) || half_q)
					st_cnt_d = st_cnt_q + 32'h1;
				if (CHG_TERM & ~lvl_q[BIT_CHG_DONE]) begin
					chg_d    = CHG_DONE;
					st_cnt_d = 32'h0;
				end else if (tmr_exp) begin
					chg_d = CHG_TFLT;
				end
			end
			CHG_DONE: begin
				st_cnt_d = 32'h0;
				if (tog || RECHARGE)
					chg_d = CHG_RUN;
			end
			CHG_TFLT: begin
				if (tog_q && !flags_q[BIT_TMR_FLT]) begin
					chg_d    = CHG_RUN;
					st_cnt_d = 32'h0;
				end
			end
			CHG_OCP: begin
				if (tog_q && !BAT_OVERCURRENT) begin
					chg_d    = CHG_RUN;
					st_cnt_d = 32'h0;
				end
			end
			default: chg_d = CHG_RUN;
		endcase
		if (BAT_OVERCURRENT & ~lvl_q[BIT_BAT_OC])
			chg_d = CHG_OCP;
		chg_en_d = chg_d == CHG_RUN;
		disc_d   = chg_d == CHG_OCP;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			chg_q          <= CHG_RUN;
			st_cnt_q       <= 32'h0;
			half_q         <= 1'b0;
			tog_q          <= 1'b0;
			ce_q           <= 1'b0;
			CHARGE_ENABLE  <= 1'b1;
			BAT_DISCONNECT <= 1'b0;
		end else begin
			chg_q          <= chg_d;
			st_cnt_q       <= st_cnt_d;
			half_q         <= half_d;
			tog_q          <= tog_d;
			ce_q           <= CE_ACTIVE;
			CHARGE_ENABLE  <= chg_en_d;
			BAT_DISCONNECT <= disc_d;
		end
	end

	ocp_off_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		BAT_OVERCURRENT && !lvl_q[BIT_BAT_OC]
		|=> !CHARGE_ENABLE && BAT_DISCONNECT)
		else $error("overcurrent did not stop charging");
	done_pause_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		chg_q == CHG_DONE |-> st_cnt_q == 32'h0 && !CHARGE_ENABLE)
		else $error("termination did not pause charging");
	tflt_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		chg_q == CHG_TFLT && flags_q[BIT_TMR_FLT] |=> chg_q != CHG_RUN)
		else $error("charging resumed with timer flag set");
endmodule

/* File: shared/fiw_pkg.sv */
package fiw_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ            = 40_000_000;
	localparam int WD_TIME_S         = 14;
	localparam int WD_CYCLES         = WD_TIME_S * CLK_HZ;
	localparam int INT_PULSE_US      = 128;
	localparam int INT_PULSE_CYCLES  = INT_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int SAFETY_CYCLES     = 1000;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam int          DATA_W     = 32;
	localparam int          NSRC       = 8;
	localparam logic [7:0]  OFS_FLAGS  = 8'h00;
	localparam logic [7:0]  OFS_CLEAR  = 8'h04;
	localparam logic [7:0]  OFS_MASK   = 8'h08;
	localparam logic [7:0]  OFS_CTRL   = 8'h0C;
	localparam logic [7:0]  OFS_STATE  = 8'h10;
	localparam logic [7:0]  MASK_RST   = 8'h00;
	localparam logic [1:0]  CTRL_RST   = 2'h0;

	// flag and mask bit positions
	localparam int BIT_CHG_DONE  = 0;
	localparam int BIT_IIN_LIM   = 1;
	localparam int BIT_VIN_REG   = 2;
	localparam int BIT_THERM     = 3;
	localparam int BIT_COOL      = 4;
	localparam int BIT_BAT_OC    = 5;
	localparam int BIT_TMR_FLT   = 6;
	localparam int BIT_WD_FLT    = 7;

	// control bit positions
	localparam int CTRL_WD_EN    = 0;
	localparam int CTRL_DBL_EN   = 1;

	// ----------------------------------------------------------------
	// state machines
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WD_IDLE  = 2'b00,
		WD_RUN   = 2'b01,
		WD_WARN  = 2'b10,
		WD_CYCLE = 2'b11
	} fiw_wd_t;

	typedef enum logic [1:0] {
		CHG_RUN   = 2'b00,
		CHG_DONE  = 2'b01,
		CHG_TFLT  = 2'b10,
		CHG_OCP   = 2'b11
	} fiw_chg_t;

endpackage

/* File: verification/fiw_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host: times interrupt pulses, answers adapter connects
// ----------------------------------------------------------------
module fiw_host_model (
	input  wire logic       clk,
	input  wire logic       int_n,
	input  wire logic       adapter,
	input  wire logic       answer,
	input  wire logic [7:0] delay,
	output logic            bus_xfer,
	output int              pulses,
	output int              width
);
	int   low_q = 0;
	logic adp_q = 1'b0;

	initial begin
		bus_xfer = 1'b0;
		pulses = 0;
		width = 0;
	end

	// low time counted in clocks, logged at release
	always @(posedge clk) begin
		adp_q <= adapter;
		if (!int_n) begin
			low_q <= low_q + 1;
		end else if (low_q != 0) begin
			pulses <= pulses + 1;
			width <= low_q;
			low_q <= 0;
		end
	end

	// one bus transaction some cycles after a connect
	always @(posedge clk) begin
		if (adapter && !adp_q && answer) begin
			repeat (delay) @(posedge clk);
			bus_xfer <= 1'b1;
			@(posedge clk);
			bus_xfer <= 1'b0;
		end
	end
endmodule

/* File: verification/test_fault_irq_and_bus_watchdog.sv */
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module test_fault_irq_and_bus_watchdog;
	import fiw_pkg::*;
	localparam int WDL = 200;
	localparam int PL  = 8;

	logic              clk   = 1'b0;
	logic              rst   = 1'b1;
	logic [ADDR_W-1:0] addr  = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic              wr    = 1'b0;
	logic              rd    = 1'b0;
	logic              sdone = 1'b0;
	logic              sflt  = 1'b0;
	logic              adp   = 1'b0;
	logic              ans   = 1'b0;
	logic              ce    = 1'b1;
	logic              rch   = 1'b0;
	logic [7:0]        dly   = 8'h14;
	logic [7:0]        lvl   = '0;
	logic [DATA_W-1:0] rdata, d;
	logic              int_o, int_oe, irq, chg_en, bat_dis, pcyc, xfer;
	wire               int_n = int_oe ? int_o : 1'b1;
	int                fails = 0, checks_done = 0, pc = 0;
	int                pulses, width, p0, b, m;

	fiw_top #(.WD_LEN(WDL), .PULSE_LEN(PL), .SAFE_LEN(50)) dut (
		.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.STARTUP_DONE(sdone), .STARTUP_FAULT(sflt), .ADAPTER_VALID(adp),
		.CE_ACTIVE(ce), .BUS_XFER(xfer), .CHG_TERM(lvl[0]),
		.RECHARGE(rch), .IIN_LIMIT(lvl[1]), .VIN_REG(lvl[2]),
		.THERM_FOLD(lvl[3]), .COOL_REGION(lvl[4]), .BAT_OVERCURRENT(lvl[5]),
		.INT_O(int_o), .INT_OE(int_oe), .IRQ(irq), .CHARGE_ENABLE(chg_en),
		.BAT_DISCONNECT(bat_dis), .POWER_CYCLE(pcyc));

	fiw_host_model host (.clk(clk), .int_n(int_n), .adapter(adp),
		.answer(ans), .delay(dly), .bus_xfer(xfer), .pulses(pulses),
		.width(width));

	// ----------------------------------------------------------------
	// clock, helpers
	// ----------------------------------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (pcyc === 1'b1) pc <= pc + 1;
	end

	function automatic logic [31:0] bitv(input int n);
		return 32'h1 << n;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// raise a source, count pulses that follow
	task automatic fire(input int s, input int n);
		p0 = pulses;
		@(posedge clk) lvl[s] <= 1'b1;
		cyc(PL + 6);
		`CHK(pulses - p0, n)
	endtask

	task automatic lower(input int s);
		@(posedge clk) lvl[s] <= 1'b0;
		cyc(2);
	endtask

	task automatic results();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#(25 * 20000);
		fails++;
		results();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h4375));
		cyc(16);
		rst <= 1'b0;
		#1 `CHK(int_oe, 1'b0)
		rd_reg(OFS_CTRL); `CHK(d, 32'h0)
		rd_reg(OFS_MASK); `CHK(d, 32'h0)
		rd_reg(8'hFC); `CHK(d, 32'h0)
		wr_reg(OFS_MASK, bitv(BIT_TMR_FLT));
		fire(BIT_IIN_LIM, 0);
		lower(BIT_IIN_LIM);
		cyc(60);
		rd_reg(OFS_FLAGS); `CHK(d[BIT_TMR_FLT], 1'b1)
		`CHK(chg_en, 1'b0)
		$display("end reset and start-up");
		@(posedge clk) sdone <= 1'b1;
		m = $urandom % 5;
		for (int i = 0; i < 5; i++) begin
			b = (i + m) % 5;
			fire(b, 1);
			`CHK(width, PL)
			`CHK(irq, 1'b1)
			rd_reg(OFS_FLAGS); `CHK(d[b], 1'b1)
			rd_reg(OFS_FLAGS); `CHK(d[b], 1'b0)
			lower(b);
		end
		$display("end sources");
		m = $urandom % 4 + 1;
		wr_reg(OFS_MASK, bitv(BIT_TMR_FLT) | bitv(m));
		fire(m, 0);
		p0 = pulses;
		wr_reg(OFS_MASK, bitv(BIT_TMR_FLT));
		cyc(PL + 6);
		`CHK(pulses - p0, 0)
		rd_reg(OFS_FLAGS);
		lower(m);
		fire(m, 1);
		lower(m);
		fire(m, 0);
		rd_reg(OFS_FLAGS);
		lower(m);
		fire(m, 1);
		rd_reg(OFS_FLAGS);
		lower(m);
		$display("end masking");
		fire(BIT_BAT_OC, 1);
		`CHK(bat_dis, 1'b1)
		`CHK(chg_en, 1'b0)
		rd_reg(OFS_FLAGS);
		lower(BIT_BAT_OC);
		$display("end overcurrent");
		@(posedge clk) adp <= 1'b1;
		cyc(WDL + 40);
		`CHK(pc, 0)
		@(posedge clk) adp <= 1'b0;
		wr_reg(OFS_CTRL, 32'h1);
		@(posedge clk) dly <= 8'($urandom_range(150, 10));
		ans <= 1'b1;
		@(posedge clk) adp <= 1'b1;
		cyc(WDL + 40);
		`CHK(pc, 0)
		@(posedge clk) adp <= 1'b0;
		ans <= 1'b0;
		cyc(2);
		p0 = pulses;
		@(posedge clk) adp <= 1'b1;
		cyc(WDL + PL + 30);
		`CHK(pc, 1)
		`CHK(pulses - p0, 1)
		rd_reg(OFS_FLAGS); `CHK(d[BIT_WD_FLT], 1'b1)
		$display("end watchdog");
		@(posedge clk) rst <= 1'b1;
		sflt <= 1'b1;
		cyc(4);
		rst <= 1'b0;
		cyc(2);
		fire(BIT_VIN_REG, 0);
		$display("end faulty start-up");
		@(posedge clk) rst <= 1'b1;
		lvl[BIT_VIN_REG] <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		wr_reg(OFS_CTRL, bitv(CTRL_DBL_EN));
		cyc(68);
		`CHK(chg_en, 1'b1)
		cyc(40);
		`CHK(chg_en, 1'b0)
		@(posedge clk) ce <= 1'b0;
		cyc(3);
		`CHK(chg_en, 1'b0)
		wr_reg(OFS_CLEAR, bitv(BIT_TMR_FLT));
		cyc(2);
		`CHK(chg_en, 1'b1)
		@(posedge clk) lvl[BIT_CHG_DONE] <= 1'b1;
		cyc(2);
		`CHK(chg_en, 1'b0)
		rd_reg(OFS_STATE); `CHK(d[5:0], {2'b00, CHG_DONE, WD_IDLE})
		@(posedge clk) rch <= 1'b1;
		cyc(2);
		`CHK(chg_en, 1'b1)
		$display("end charger");
		results();
	end
endmodule
